// ### hdl/selvc_regbank.sv
// Behaviour
// - Severity bits 0-3,5-13 sticky RW; 6,8,9,12 reset one; rest zero.
// - Five-bit sticky pointer names first logged error, resets to zero.
// - Log bits 35:0 hold attribute phase byte enables and address/data.
// - Log bits 39:36 hold command lines of first address phase.
// - Log bits 43:40 hold dual-cycle second command; 63:44 read zero.
// - Log bits 95:64 hold first address phase address.
// - Log bits 127:96 hold dual-cycle second address; all sticky, RO.
// - Log spans four dwords; the dword after it is reserved zero.
// - Channel header returns identifier 0002h in bits 15:0.
// - Channel header returns version 1 in bits 19:16.
// - Channel header next pointer reads zero, ending the list.
// - First port channel capability dword reads all zero.
// - Second port channel capability dword reads zero.
// - Port channel control half reads zero; writes ignored.
// - Port channel status bit 16 always reads zero.
// - Channel 0 resource capability dword reads all zero.
// - Resource control: TC0 map one, TC7..1 RW reset 7Fh, ID 0, enable 1.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
module selvc_regbank
    import selvc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        hot_rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        err_valid,
    input  wire logic [4:0]  err_code,
    input  wire logic [13:0] err_mask,
    input  wire logic [3:0]  hdr_attr_cbe,
    input  wire logic [31:0] hdr_attr_ad,
    input  wire logic [3:0]  hdr_cmd_lo,
    input  wire logic [3:0]  hdr_cmd_hi,
    input  wire logic [31:0] hdr_addr_lo,
    input  wire logic [31:0] hdr_addr_hi,
    input  wire logic        hdr_dac,
    output logic             err_fatal,
    output logic             err_nonfatal,
    output logic [7:0]       tc_map,
    output logic             log_held,
    output logic             irq
);

    // Address match against a register offset
    function automatic logic addr_is(
        input logic [11:0] a,
        input logic [11:0] ofs
    );
        addr_is = (a == ofs);
    endfunction : addr_is

    logic [13:0]              sev_ff;
    logic [SELVC_PTR_W-1:0]   ptr_ff;
    logic [127:0]             hlog_ff;
    logic [127:0]             nxt_hlog;
    logic [6:0]               tcmap_ff;
    logic [31:0]              prdata_ff;
    logic [31:0]              nxt_prdata;
    logic                     pslverr_ff;
    logic                     nxt_err;
    selvc_log_type            log_ff;
    logic [31:0]              hword [0:SELVC_HLOG_WDS-1];
    logic                     setup;
    logic                     wr_acc;
    logic                     accept;
    logic                     cap;
    logic                     rearm;
    logic                     wr_sts;
    logic                     wr_msk;
    logic [SELVC_IRQ_W-1:0]   evt;
    logic [SELVC_IRQ_W-1:0]   sts;
    logic [SELVC_IRQ_W-1:0]   msk;
    logic [31:0]              vc_hdr;
    logic [31:0]              r0ctl;

    // Bus phase decode
    assign setup  = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign pready = 1'b1;

    // Derived write strobes
    assign wr_sts = wr_acc & addr_is(paddr, SELVC_ISTS_OFS);
    assign wr_msk = wr_acc & addr_is(paddr, SELVC_IMSK_OFS);
    assign rearm  = wr_sts & pwdata[SELVC_IRQ_LOG];

    // Fixed capability header word
    assign vc_hdr = {SELVC_VC_NEXT,
                     SELVC_VC_VER,
                     SELVC_VC_ID};

    // Resource control readback
    assign r0ctl = {SELVC_VC_EN,
                    4'h0,
                    SELVC_VC_NUM,
                    16'h0000,
                    tcmap_ff,
                    SELVC_TC0_MAP};

    // Error classification
    selvc_err_classify u_classify (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .err_valid   (err_valid),
        .err_code    (err_code),
        .err_mask    (err_mask),
        .sev         (sev_ff),
        .accept      (accept),
        .fatal_ff    (err_fatal),
        .nonfatal_ff (err_nonfatal)
    );

    // Capture only while the log is free
    assign cap = accept && (log_ff == SELVC_LOG_EMPTY);

    // Interrupt events
    always_comb
    begin
        evt                 = '0;
        evt[SELVC_IRQ_FAT]  = err_fatal;
        evt[SELVC_IRQ_NFAT] = err_nonfatal;
        evt[SELVC_IRQ_LOG]  = cap;
    end

    // Status, mask and interrupt line
    selvc_irq u_irq (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .evt     (evt),
        .wr_sts  (wr_sts),
        .wr_msk  (wr_msk),
        .wdata   (pwdata[SELVC_IRQ_W-1:0]),
        .sts_ff  (sts),
        .msk_ff  (msk),
        .irq     (irq)
    );

    // Severity register, sticky over hot reset
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sev_ff <= SELVC_SEV_RST;
        else if (wr_acc && addr_is(paddr, SELVC_SEV_OFS))
            sev_ff <= pwdata[13:0] & SELVC_SEV_WMSK;
    end

    // Log occupancy, re-armed by clearing its status bit
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            log_ff <= SELVC_LOG_EMPTY;
        else
        begin
            case (log_ff)
                SELVC_LOG_EMPTY:
                begin
                    if (cap)
                        log_ff <= SELVC_LOG_HELD;
                end
                SELVC_LOG_HELD:
                begin
                    if (rearm)
                        log_ff <= SELVC_LOG_EMPTY;
                end
                default:
                    log_ff <= SELVC_LOG_EMPTY;
            endcase
        end
    end

    assign log_held = (log_ff == SELVC_LOG_HELD);

    // First error pointer, sticky read-only
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            ptr_ff <= '0;
        else if (cap)
            ptr_ff <= err_code;
    end

    // Header log image of the failing transaction
    always_comb
    begin
        nxt_hlog = {hdr_dac ? hdr_addr_hi : 32'h0,
                    hdr_addr_lo,
                    SELVC_HLOG_RSV,
                    hdr_dac ? hdr_cmd_hi : 4'h0,
                    hdr_cmd_lo,
                    hdr_attr_cbe,
                    hdr_attr_ad};
    end

    // Header log storage, sticky read-only
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            hlog_ff <= '0;
        else if (cap)
            hlog_ff <= nxt_hlog;
    end

    // Split log into readable dwords
    generate
        for (genvar k = 0; k < SELVC_HLOG_WDS; k++)
        begin : g_hword
            assign hword[k] = hlog_ff[32*k +: 32];
        end
    endgenerate

    // Traffic class map, restored by hot reset
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            tcmap_ff <= SELVC_TCMAP_RST;
        else if (hot_rst)
            tcmap_ff <= SELVC_TCMAP_RST;
        else if (wr_acc && addr_is(paddr, SELVC_R0CTL_OFS))
            tcmap_ff <= pwdata[7:1];
    end

    assign tc_map = {tcmap_ff, SELVC_TC0_MAP};

    // Read decode and unmapped detection
    always_comb
    begin
        nxt_prdata = 32'h0;
        nxt_err    = 1'b0;
        if (addr_is(paddr, SELVC_SEV_OFS))
            nxt_prdata = {18'h0, sev_ff};
        else if (addr_is(paddr, SELVC_PTR_OFS))
            nxt_prdata = {27'h0, ptr_ff};
        else if (addr_is(paddr, SELVC_RSV_OFS))
            nxt_prdata = 32'h0;
        else if (addr_is(paddr, SELVC_VCHDR_OFS))
            nxt_prdata = vc_hdr;
        else if (addr_is(paddr, SELVC_PCAP1_OFS))
            nxt_prdata = 32'h0;
        else if (addr_is(paddr, SELVC_PCAP2_OFS))
            nxt_prdata = 32'h0;
        else if (addr_is(paddr, SELVC_PCTL_OFS))
            nxt_prdata = 32'h0;
        else if (addr_is(paddr, SELVC_R0CAP_OFS))
            nxt_prdata = 32'h0;
        else if (addr_is(paddr, SELVC_R0CTL_OFS))
            nxt_prdata = r0ctl;
        else if (addr_is(paddr, SELVC_ISTS_OFS))
            nxt_prdata = {29'h0, sts};
        else if (addr_is(paddr, SELVC_IMSK_OFS))
            nxt_prdata = {29'h0, msk};
        else
            nxt_err = 1'b1;
        for (int k = 0; k < SELVC_HLOG_WDS; k++)
        begin
            if (addr_is(paddr, SELVC_HLOG_OFS + 12'(4 * k)))
            begin
                nxt_prdata = hword[k];
                nxt_err    = 1'b0;
            end
        end
    end

    // Read data held from setup into access phase
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
        end
        else if (setup)
        begin
            prdata_ff  <= pwrite ? 32'h0 : nxt_prdata;
            pslverr_ff <= nxt_err;
        end
    end

    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff & psel & penable;

    AST_SEV_WRITE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        wr_acc && addr_is(paddr, SELVC_SEV_OFS)
        |=> sev_ff == ($past(pwdata[13:0]) & SELVC_SEV_WMSK))
        else $error("severity write wrong");

    AST_PTR_CAPTURE: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cap |=> ptr_ff == $past(err_code) && log_held)
        else $error("pointer not captured");

    AST_HLOG_FIELDS: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cap |=> hlog_ff[95:64] == $past(hdr_addr_lo)
             && hlog_ff[39:36] == $past(hdr_cmd_lo)
             && hlog_ff[35:0] == $past({hdr_attr_cbe, hdr_attr_ad}))
        else $error("header log fields wrong");

    AST_HLOG_SAC: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        cap && !hdr_dac |=> hlog_ff[127:96] == 32'h0
                         && hlog_ff[63:40] == 24'h0)
        else $error("single cycle log not zeroed");

    AST_HLOG_HOLD: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        log_held && !rearm |=> $stable(hlog_ff) && $stable(ptr_ff))
        else $error("held log changed");

    AST_VCHDR_READ: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        setup && !pwrite && addr_is(paddr, SELVC_VCHDR_OFS)
        |=> prdata == 32'h00010002)
        else $error("capability header wrong");

    AST_ZERO_CAPS: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        setup && (addr_is(paddr, SELVC_PCAP1_OFS)
               || addr_is(paddr, SELVC_PCAP2_OFS)
               || addr_is(paddr, SELVC_PCTL_OFS)
               || addr_is(paddr, SELVC_R0CAP_OFS))
        |=> prdata == 32'h0 && !pslverr)
        else $error("fixed capability not zero");

    AST_R0CTL_READ: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        setup && !pwrite && addr_is(paddr, SELVC_R0CTL_OFS)
        |=> prdata[31] && prdata[0] && prdata[26:24] == 3'h0
         && prdata[7:1] == $past(tcmap_ff))
        else $error("resource control wrong");

    // Hot reset restores the map only, leaves sticky severity alone
    AST_TCMAP_HOT: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        hot_rst |=> tcmap_ff == SELVC_TCMAP_RST)
        else $error("map not restored by hot reset");

    AST_SEV_STICKY: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        hot_rst && !(wr_acc && addr_is(paddr, SELVC_SEV_OFS))
        |=> $stable(sev_ff))
        else $error("severity lost on hot reset");

    // Clearing the log status bit frees the log
    AST_LOG_REARM: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        log_held && rearm |=> !log_held)
        else $error("log not re-armed");

endmodule : selvc_regbank

// ### hdl/selvc_pkg.sv
package selvc_pkg;

    // Register byte offsets
    localparam logic [11:0] SELVC_SEV_OFS   = 12'h134;
    localparam logic [11:0] SELVC_PTR_OFS   = 12'h138;
    localparam logic [11:0] SELVC_HLOG_OFS  = 12'h13C;
    localparam logic [11:0] SELVC_RSV_OFS   = 12'h14C;
    localparam logic [11:0] SELVC_VCHDR_OFS = 12'h150;
    localparam logic [11:0] SELVC_PCAP1_OFS = 12'h154;
    localparam logic [11:0] SELVC_PCAP2_OFS = 12'h158;
    localparam logic [11:0] SELVC_PCTL_OFS  = 12'h15C;
    localparam logic [11:0] SELVC_R0CAP_OFS = 12'h160;
    localparam logic [11:0] SELVC_R0CTL_OFS = 12'h164;
    localparam logic [11:0] SELVC_ISTS_OFS  = 12'h180;
    localparam logic [11:0] SELVC_IMSK_OFS  = 12'h184;

    // Severity register layout
    localparam int          SELVC_ERR_CNT   = 14;
    localparam logic [4:0]  SELVC_RSV_CODE  = 5'h04;
    localparam logic [13:0] SELVC_SEV_RST   = 14'h1340;
    localparam logic [13:0] SELVC_SEV_WMSK  = 14'h3FEF;

    // Header log layout
    localparam int          SELVC_HLOG_WDS  = 4;
    localparam int          SELVC_PTR_W     = 5;
    localparam logic [19:0] SELVC_HLOG_RSV  = 20'h00000;

    // Channel capability constants
    localparam logic [15:0] SELVC_VC_ID     = 16'h0002;
    localparam logic [3:0]  SELVC_VC_VER    = 4'h1;
    localparam logic [11:0] SELVC_VC_NEXT   = 12'h000;
    localparam logic [6:0]  SELVC_TCMAP_RST = 7'h7F;
    localparam logic [2:0]  SELVC_VC_NUM    = 3'h0;
    localparam logic        SELVC_TC0_MAP   = 1'b1;
    localparam logic        SELVC_VC_EN     = 1'b1;

    // Interrupt status bit positions
    localparam int          SELVC_IRQ_W     = 3;
    localparam int          SELVC_IRQ_FAT   = 0;
    localparam int          SELVC_IRQ_NFAT  = 1;
    localparam int          SELVC_IRQ_LOG   = 2;

    // Log capture state
    typedef enum logic [1:0] {
        SELVC_LOG_EMPTY = 2'b01,
        SELVC_LOG_HELD  = 2'b10
    } selvc_log_type;

endpackage : selvc_pkg

// ### hdl/selvc_err_classify.sv
`timescale 1ns/1ps
module selvc_err_classify
    import selvc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        err_valid,
    input  wire logic [4:0]  err_code,
    input  wire logic [13:0] err_mask,
    input  wire logic [13:0] sev,
    output logic             accept,
    output logic             fatal_ff,
    output logic             nonfatal_ff
);

    // Legal, unreserved and unmasked error
    assign accept = err_valid
                  && (err_code < 5'(SELVC_ERR_CNT))
                  && (err_code != SELVC_RSV_CODE)
                  && !err_mask[err_code[3:0]];

    // Severity picks fatal or non-fatal
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fatal_ff    <= 1'b0;
            nonfatal_ff <= 1'b0;
        end
        else
        begin
            fatal_ff    <= accept & sev[err_code[3:0]];
            nonfatal_ff <= accept & ~sev[err_code[3:0]];
        end
    end

    AST_FATAL_CLASS: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        accept && sev[err_code[3:0]] |=> fatal_ff && !nonfatal_ff)
        else $error("fatal class missed");

    AST_NONFATAL_CLASS: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        accept && !sev[err_code[3:0]] |=> nonfatal_ff && !fatal_ff)
        else $error("non-fatal class missed");

endmodule : selvc_err_classify

// ### hdl/selvc_irq.sv
`timescale 1ns/1ps
module selvc_irq
    import selvc_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic [SELVC_IRQ_W-1:0] evt,
    input  wire logic                   wr_sts,
    input  wire logic                   wr_msk,
    input  wire logic [SELVC_IRQ_W-1:0] wdata,
    output logic      [SELVC_IRQ_W-1:0] sts_ff,
    output logic      [SELVC_IRQ_W-1:0] msk_ff,
    output logic                        irq
);

    // Sticky status, set wins over write-one clear
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            sts_ff <= '0;
        else
            sts_ff <= (sts_ff & ~({SELVC_IRQ_W{wr_sts}} & wdata)) | evt;
    end

    // Enable mask
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            msk_ff <= '0;
        else if (wr_msk)
            msk_ff <= wdata;
    end

    assign irq = |(sts_ff & msk_ff);

    AST_IRQ_SET_WINS: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        |(evt & msk_ff) && !wr_msk |=> irq)
        else $error("event lost or not raised");

endmodule : selvc_irq

// ### verif/test_secondary_error_log_and_vc_caps.sv
`timescale 1ns/1ps
module test_secondary_error_log_and_vc_caps
    import selvc_pkg::*;
    ;

    logic        sys_clk, sys_rst, hot_rst;
    logic [11:0] paddr;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [31:0] pwdata, prdata;
    logic        err_valid, hdr_dac, err_fatal, err_nonfatal;
    logic [4:0]  err_code, c, ptr_m;
    logic [13:0] err_mask, sev_m;
    logic [3:0]  hdr_attr_cbe, hdr_cmd_lo, hdr_cmd_hi, c_cbe, c_lo, c_hi;
    logic [31:0] hdr_attr_ad, hdr_addr_lo, hdr_addr_hi;
    logic [31:0] c_ad, c_alo, c_ahi, rd, d, seed;
    logic [7:0]  tc_map;
    logic        log_held, irq, se, c_dac, held_m;
    logic [2:0]  sts_m, msk_m;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [11:0] ro_a [11] = '{SELVC_PTR_OFS, SELVC_HLOG_OFS,
        SELVC_HLOG_OFS + 12'h4, SELVC_HLOG_OFS + 12'h8,
        SELVC_HLOG_OFS + 12'hC, SELVC_RSV_OFS, SELVC_VCHDR_OFS,
        SELVC_PCAP1_OFS, SELVC_PCAP2_OFS, SELVC_PCTL_OFS, SELVC_R0CAP_OFS};

    selvc_regbank uut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hot_rst(hot_rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .err_valid(err_valid), .err_code(err_code),
        .err_mask(err_mask), .hdr_attr_cbe(hdr_attr_cbe),
        .hdr_attr_ad(hdr_attr_ad), .hdr_cmd_lo(hdr_cmd_lo),
        .hdr_cmd_hi(hdr_cmd_hi), .hdr_addr_lo(hdr_addr_lo),
        .hdr_addr_hi(hdr_addr_hi), .hdr_dac(hdr_dac),
        .err_fatal(err_fatal), .err_nonfatal(err_nonfatal),
        .tc_map(tc_map), .log_held(log_held), .irq(irq)
    );

    // Free-running system clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Cycle ceiling against a hung handshake
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            test_done();
        end
    end

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk(32'(se), 32'h0);
    endtask : rd_chk

    // Expected header log word from the captured snapshot
    function automatic logic [31:0] exp_log(input int k);
        case (k)
            0: exp_log = c_ad;
            1: exp_log = {20'h0, c_dac ? c_hi : 4'h0, c_lo, c_cbe};
            2: exp_log = c_alo;
            default: exp_log = c_dac ? c_ahi : 32'h0;
        endcase
    endfunction : exp_log

    task automatic check_log();
        rd_chk(SELVC_HLOG_OFS, exp_log(0));
        rd_chk(SELVC_HLOG_OFS + 12'h4, exp_log(1));
        rd_chk(SELVC_HLOG_OFS + 12'h8, exp_log(2));
        rd_chk(SELVC_HLOG_OFS + 12'hC, exp_log(3));
    endtask : check_log

    // One error event with a random transaction snapshot
    task automatic inject(input logic [4:0] code, input logic dac,
                          input logic [13:0] msk);
        logic acc;
        err_valid    <= 1'b1;
        err_code     <= code;
        err_mask     <= msk;
        hdr_attr_cbe <= 4'($urandom);
        hdr_attr_ad  <= $urandom;
        hdr_cmd_lo   <= 4'($urandom);
        hdr_cmd_hi   <= 4'($urandom);
        hdr_addr_lo  <= $urandom;
        hdr_addr_hi  <= $urandom;
        hdr_dac      <= dac;
        @(posedge sys_clk);
        err_valid <= 1'b0;
        acc = code < 5'd14 && code != 5'd4 && !msk[code[3:0]];
        if (acc && !held_m)
        begin
            c_cbe = hdr_attr_cbe;
            c_ad = hdr_attr_ad;
            c_lo = hdr_cmd_lo;
            c_hi = hdr_cmd_hi;
            c_alo = hdr_addr_lo;
            c_ahi = hdr_addr_hi;
            c_dac = hdr_dac;
            ptr_m = code;
            held_m = 1'b1;
            sts_m[2] = 1'b1;
        end
        if (acc)
            sts_m[sev_m[code[3:0]] ? 0 : 1] = 1'b1;
        #1;
        chk(32'(err_fatal), 32'(acc && sev_m[code[3:0]]));
        chk(32'(err_nonfatal), 32'(acc && !sev_m[code[3:0]]));
        chk(32'(log_held), 32'(held_m));
        chk(32'(irq), 32'(|(sts_m & msk_m)));
        @(posedge sys_clk);
    endtask : inject

    // Main sequence
    initial
    begin
        {sys_rst, hot_rst, psel, penable, pwrite, err_valid} = 6'h20;
        {paddr, pwdata, err_code, err_mask, hdr_dac} = '0;
        {hdr_attr_cbe, hdr_cmd_lo, hdr_cmd_hi} = '0;
        {hdr_attr_ad, hdr_addr_lo, hdr_addr_hi} = '0;
        {c_cbe, c_lo, c_hi, c_ad, c_alo, c_ahi, c_dac} = '0;
        {ptr_m, held_m, sts_m, msk_m} = '0;
        sev_m = 14'h1340;
        seed = $urandom(32'h9A43);
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        foreach (ro_a[i])
            apb(1'b1, ro_a[i], 32'hFFFF_FFFF);
        rd_chk(SELVC_SEV_OFS, 32'h0000_1340);
        rd_chk(SELVC_PTR_OFS, 32'h0);
        for (int k = 0; k < 5; k++)
            rd_chk(SELVC_HLOG_OFS + 12'(4 * k), 32'h0);
        apb(1'b0, SELVC_VCHDR_OFS, 32'h0);
        chk(rd & 32'h0000_FFFF, 32'h0000_0002);
        chk(rd & 32'h000F_0000, 32'h0001_0000);
        chk(rd & 32'hFFF0_0000, 32'h0);
        rd_chk(SELVC_PCAP1_OFS, 32'h0);
        rd_chk(SELVC_PCAP2_OFS, 32'h0);
        apb(1'b0, SELVC_PCTL_OFS, 32'h0);
        chk(rd & 32'h0000_FFFF, 32'h0);
        chk(rd & 32'h0001_0000, 32'h0);
        rd_chk(SELVC_R0CAP_OFS, 32'h0);
        rd_chk(SELVC_R0CTL_OFS, 32'h8000_00FF);
        chk(32'(tc_map), 32'h0000_00FF);
        apb(1'b0, 12'h168, 32'h0);
        chk({31'h0, se}, 32'h1);
        chk(rd, 32'h0);
        $display("Test reset_and_read_only done");
        apb(1'b1, SELVC_SEV_OFS, 32'hFFFF_FFFF);
        rd_chk(SELVC_SEV_OFS, 32'h0000_3FEF);
        d = $urandom;
        apb(1'b1, SELVC_SEV_OFS, d);
        sev_m = d[13:0] & 14'h3FEF;
        rd_chk(SELVC_SEV_OFS, {18'h0, sev_m});
        apb(1'b1, SELVC_IMSK_OFS, 32'h7);
        msk_m = 3'h7;
        c = 5'($urandom_range(13, 5));
        inject(c, 1'b1, 14'h1 << c);
        inject(c, 1'b1, 14'h0);
        rd_chk(SELVC_PTR_OFS, {27'h0, ptr_m});
        check_log();
        for (int k = 0; k < 16; k++)
            inject(5'(k), 1'(k), 14'($urandom));
        check_log();
        rd_chk(SELVC_PTR_OFS, {27'h0, ptr_m});
        rd_chk(SELVC_ISTS_OFS, {29'h0, sts_m});
        apb(1'b1, SELVC_IMSK_OFS, 32'h0);
        msk_m = 3'h0;
        chk(32'(irq), 32'h0);
        apb(1'b1, SELVC_IMSK_OFS, 32'h7);
        msk_m = 3'h7;
        chk(32'(irq), 32'(|sts_m));
        $display("Test error_capture done");
        d = $urandom;
        apb(1'b1, SELVC_R0CTL_OFS, d);
        rd_chk(SELVC_R0CTL_OFS, {1'b1, 23'h0, d[7:1], 1'b1});
        chk(32'(tc_map), {24'h0, d[7:1], 1'b1});
        hot_rst <= 1'b1;
        @(posedge sys_clk);
        hot_rst <= 1'b0;
        @(posedge sys_clk);
        chk(32'(tc_map), 32'h0000_00FF);
        rd_chk(SELVC_SEV_OFS, {18'h0, sev_m});
        check_log();
        $display("Test hot_reset done");
        apb(1'b1, SELVC_ISTS_OFS, 32'h4);
        sts_m[2] = 1'b0;
        held_m = 1'b0;
        @(posedge sys_clk);
        chk(32'(log_held), 32'h0);
        c = 5'($urandom_range(3, 0));
        inject(c, 1'b0, 14'h0);
        rd_chk(SELVC_PTR_OFS, {27'h0, ptr_m});
        check_log();
        apb(1'b1, SELVC_ISTS_OFS, 32'h7);
        sts_m = 3'h0;
        chk(32'(irq), 32'h0);
        $display("Test rearm_and_clear done");
        test_done();
    end

endmodule : test_secondary_error_log_and_vc_caps
